// *** rtl/asp_pkg.sv ***
// shared constants and types for the converter serial host port
`default_nettype none
package asp_pkg;
  localparam int RESULT_WIDTH = 14;
  localparam int NUM_CHANNELS = 8;
  localparam int CHAN_WIDTH = 3;
  localparam int RANGE_WIDTH = 3;
  localparam int CFG_BYTE_WIDTH = 8;
  localparam int BIT_CNT_WIDTH = 4;
  localparam int FIFO_DEPTH = 16;
  // configuration byte field positions
  localparam int CFG_START_POS = 7;
  localparam int CFG_CHAN_MSB = 6;
  localparam int CFG_CHAN_LSB = 4;
  localparam int CFG_DIFF_POS = 3;
  localparam int CFG_RANGE_MSB = 2;
  localparam int CFG_RANGE_LSB = 0;
  // reset values and the config byte bit count
  localparam logic CFG_DIFF_RESET = 1'h0;
  localparam logic [RANGE_WIDTH-1:0] CFG_RANGE_RESET = 3'h0;
  localparam logic [3:0] BITS_PER_CFG = 4'h8;

  typedef struct packed {
    logic cs_n;
    logic sclk;
    logic din;
  } asp_pins_type;

  typedef struct packed {
    logic differential_select;
    logic [RANGE_WIDTH-1:0] range;
  } asp_cfg_type;

  typedef enum {
    ASP_WAIT_START,
    ASP_COLLECT,
    ASP_DONE
  } asp_cfg_state_type;
endpackage : asp_pkg
`default_nettype wire

// *** rtl/asp_fifo.sv ***
// result fifo with registered read stage
`default_nettype none
module asp_fifo
  import asp_pkg::*;
#(
  parameter int WIDTH = RESULT_WIDTH,
  parameter int DEPTH = FIFO_DEPTH
) (
  input wire logic clock_i,
  input wire logic rst_n_i,
  input wire logic in_valid_i,
  input wire logic [WIDTH-1:0] in_data_i,
  output logic in_ready_o,
  output logic out_valid_o,
  output logic [WIDTH-1:0] out_data_o,
  input wire logic out_ready_i
);
  localparam int PW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [PW-1:0] wr_ptr_reg, wr_ptr_next, rd_ptr_reg, rd_ptr_next;
  logic [PW:0] count_reg, count_next;
  logic out_valid_reg, out_valid_next;
  logic [WIDTH-1:0] out_data_reg, out_data_next;
  logic push, load;

  // pointer and output stage next values; the read stage adds one word of slack
  always_comb begin
    push = in_valid_i && (count_reg < (PW+1)'(DEPTH));
    load = (count_reg != '0) && (!out_valid_reg || out_ready_i);
    wr_ptr_next = push ? wr_ptr_reg + 1'b1 : wr_ptr_reg;
    rd_ptr_next = load ? rd_ptr_reg + 1'b1 : rd_ptr_reg;
    count_next = count_reg + (PW+1)'(push) - (PW+1)'(load);
    out_valid_next = load ? 1'b1 : (out_ready_i ? 1'b0 : out_valid_reg);
    out_data_next = load ? mem[rd_ptr_reg] : out_data_reg;
  end

  always_ff @(posedge clock_i) begin
    if (!rst_n_i) begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
      count_reg <= '0;
      out_valid_reg <= 1'b0;
      out_data_reg <= '0;
    end else begin
      wr_ptr_reg <= wr_ptr_next;
      rd_ptr_reg <= rd_ptr_next;
      count_reg <= count_next;
      out_valid_reg <= out_valid_next;
      out_data_reg <= out_data_next;
    end
  end

  // storage needs no reset, contents are guarded by count
  always_ff @(posedge clock_i) begin
    if (push) begin
      mem[wr_ptr_reg] <= in_data_i;
    end
  end

  assign in_ready_o = (count_reg < (PW+1)'(DEPTH));
  assign out_valid_o = out_valid_reg;
  assign out_data_o = out_data_reg;
endmodule : asp_fifo
`default_nettype wire

// *** rtl/asp_serial_port.sv ***
// serial host port: config byte capture, result shift-out, ready strobe
`default_nettype none
// Summary of operation
// - with chip select low, sample serial input on each serial clock rise.
// - with chip select high, serial input changes are ignored.
// - with chip select high, serial clock edges shift nothing.
// - with chip select low, each serial clock fall presents the next output bit.
// - serial output is released (high impedance) while chip select is high.
// - internal clock mode: strobe rises when a result is ready to read.
// - external clock mode: strobe stays low all the time.
// - strobe is always driven; host gives it its own input line.
// - each conversion result is fourteen bits wide.
// - separate config per channel: range code plus single/differential choice.
// - first one bit after chip select falls is the config byte's top bit.
// - bits 6..4 channel, bit 3 differential, bits 2..0 range.
// - a differential pair uses the config of its positive channel.
module asp_serial_port
  import asp_pkg::*;
#(
  parameter int CHANNELS = NUM_CHANNELS,
  parameter int DEPTH = FIFO_DEPTH
) (
  input wire logic clock_i,
  input wire logic rst_n_i,
  input wire logic cs_n_i,
  input wire logic sclk_i,
  input wire logic din_i,
  output logic dout_o,
  output logic dout_oe_o,
  output logic result_ready_strobe_o,
  input wire logic internal_clock_mode_i,
  input wire logic result_valid_i,
  input wire logic [RESULT_WIDTH-1:0] result_data_i,
  output logic result_ready_o,
  input wire logic [CHAN_WIDTH-1:0] conv_channel_i,
  output logic [RANGE_WIDTH:0] conv_cfg_o,
  output logic cfg_update_o
);
  asp_pins_type pins_meta_reg, pins_sync_reg, pins_prev_reg;
  logic cs_fall, cs_low, sclk_rise, sclk_fall;
  logic fifo_in_ready, fifo_out_valid, fifo_pop;
  logic [RESULT_WIDTH-1:0] fifo_out_data;
  asp_cfg_state_type state_reg, state_next;
  logic [CFG_BYTE_WIDTH-1:0] byte_reg, byte_next;
  logic [BIT_CNT_WIDTH-1:0] bit_cnt_reg, bit_cnt_next;
  asp_cfg_type cfg_reg [CHANNELS];
  logic cfg_write;
  logic [CHAN_WIDTH-1:0] cfg_chan;
  logic [RESULT_WIDTH-1:0] shift_reg, shift_next;
  logic dout_reg, dout_next, oe_reg, oe_next, strobe_reg, strobe_next;
  logic update_reg, update_next, ready_reg, ready_next;
  logic [RANGE_WIDTH:0] conv_cfg_reg, conv_cfg_next;
  logic [CHAN_WIDTH-1:0] pos_chan;

  // pins are asynchronous: two flops, then a third stage for edge finding
  always_ff @(posedge clock_i) begin
    if (!rst_n_i) begin
      pins_meta_reg <= '{cs_n: 1'b1, sclk: 1'b0, din: 1'b0};
      pins_sync_reg <= '{cs_n: 1'b1, sclk: 1'b0, din: 1'b0};
      pins_prev_reg <= '{cs_n: 1'b1, sclk: 1'b0, din: 1'b0};
    end else begin
      pins_meta_reg <= '{cs_n: cs_n_i, sclk: sclk_i, din: din_i};
      pins_sync_reg <= pins_meta_reg;
      pins_prev_reg <= pins_sync_reg;
    end
  end

  // edges only count while selected, so an idle select masks the link
  always_comb begin
    cs_low = !pins_sync_reg.cs_n;
    cs_fall = pins_prev_reg.cs_n && !pins_sync_reg.cs_n;
    sclk_rise = cs_low && !cs_fall && pins_sync_reg.sclk && !pins_prev_reg.sclk;
    sclk_fall = cs_low && !cs_fall && !pins_sync_reg.sclk && pins_prev_reg.sclk;
  end

  // results from the converter core queue here until the host reads them
  asp_fifo #(
    .WIDTH(RESULT_WIDTH),
    .DEPTH(DEPTH)
  ) u_fifo (
    .clock_i(clock_i),
    .rst_n_i(rst_n_i),
    .in_valid_i(result_valid_i),
    .in_data_i(result_data_i),
    .in_ready_o(fifo_in_ready),
    .out_valid_o(fifo_out_valid),
    .out_data_o(fifo_out_data),
    .out_ready_i(fifo_pop)
  );

  // configuration byte receiver: leading zeros skipped until the start bit
  always_comb begin
    state_next = state_reg;
    byte_next = byte_reg;
    bit_cnt_next = bit_cnt_reg;
    cfg_write = 1'b0;
    if (cs_fall) begin
      state_next = ASP_WAIT_START;
      bit_cnt_next = '0;
      byte_next = '0;
    end else if (sclk_rise) begin
      case (state_reg)
        ASP_WAIT_START: begin
          if (pins_sync_reg.din) begin
            byte_next = {{(CFG_BYTE_WIDTH-1){1'b0}}, 1'b1};
            bit_cnt_next = 4'h1;
            state_next = ASP_COLLECT;
          end
        end
        ASP_COLLECT: begin
          byte_next = {byte_reg[CFG_BYTE_WIDTH-2:0], pins_sync_reg.din};
          bit_cnt_next = bit_cnt_reg + 4'h1;
          if (bit_cnt_next == BITS_PER_CFG) begin
            cfg_write = 1'b1;
            state_next = ASP_DONE;
          end
        end
        ASP_DONE: begin
          state_next = ASP_DONE;
        end
        default: begin
          state_next = ASP_WAIT_START;
        end
      endcase
    end
    // channel field of the byte as it will stand after this edge
    cfg_chan = byte_next[CFG_CHAN_MSB:CFG_CHAN_LSB];
  end

  always_ff @(posedge clock_i) begin
    if (!rst_n_i) begin
      state_reg <= ASP_WAIT_START;
      byte_reg <= '0;
      bit_cnt_reg <= '0;
    end else begin
      state_reg <= state_next;
      byte_reg <= byte_next;
      bit_cnt_reg <= bit_cnt_next;
    end
  end

  // per-channel config store, written when the eighth bit arrives
  always_ff @(posedge clock_i) begin
    if (!rst_n_i) begin
      for (int i = 0; i < CHANNELS; i++) begin
        cfg_reg[i] <= '{differential_select: CFG_DIFF_RESET, range: CFG_RANGE_RESET};
      end
    end else if (cfg_write) begin
      // byte_next holds the full byte in the write cycle
      cfg_reg[cfg_chan] <= '{
        differential_select: byte_next[CFG_DIFF_POS],
        range: byte_next[CFG_RANGE_MSB:CFG_RANGE_LSB]
      };
    end
  end

  // output shifter, result register, strobe and status
  always_comb begin
    fifo_pop = 1'b0;
    shift_next = shift_reg;
    dout_next = dout_reg;
    if (cs_fall) begin
      // take a queued result at frame start; none queued shifts zeros
      fifo_pop = fifo_out_valid;
      shift_next = fifo_out_valid ? fifo_out_data : '0;
      dout_next = 1'b0;
    end else if (sclk_fall) begin
      dout_next = shift_reg[RESULT_WIDTH-1];
      shift_next = {shift_reg[RESULT_WIDTH-2:0], 1'b0};
    end
    oe_next = cs_low;
    // strobe tracks a waiting result only in internal clock mode
    strobe_next = internal_clock_mode_i && fifo_out_valid && !fifo_pop;
    update_next = cfg_write;
    ready_next = fifo_in_ready;
    // the even, positive channel's stored config decides whether the pair is differential
    pos_chan = cfg_reg[{conv_channel_i[CHAN_WIDTH-1:1], 1'b0}].differential_select
             ? {conv_channel_i[CHAN_WIDTH-1:1], 1'b0}
             : conv_channel_i;
    conv_cfg_next = cfg_reg[pos_chan];
  end

  always_ff @(posedge clock_i) begin
    if (!rst_n_i) begin
      shift_reg <= '0;
      dout_reg <= 1'b0;
      oe_reg <= 1'b0;
      strobe_reg <= 1'b0;
      update_reg <= 1'b0;
      ready_reg <= 1'b0;
      conv_cfg_reg <= '0;
    end else begin
      shift_reg <= shift_next;
      dout_reg <= dout_next;
      oe_reg <= oe_next;
      strobe_reg <= strobe_next;
      update_reg <= update_next;
      ready_reg <= ready_next;
      conv_cfg_reg <= conv_cfg_next;
    end
  end

  assign dout_o = dout_reg;
  assign dout_oe_o = oe_reg;
  assign result_ready_strobe_o = strobe_reg;
  assign cfg_update_o = update_reg;
  assign result_ready_o = ready_reg;
  assign conv_cfg_o = conv_cfg_reg;
endmodule : asp_serial_port
`default_nettype wire

// *** sim/asp_port_props.sv ***
// pin-level assertions for the converter serial port
`default_nettype none
module asp_port_props (
  input wire logic clock_i,
  input wire logic rst_n_i,
  input wire logic cs_n_i,
  input wire logic sclk_i,
  input wire logic dout_o,
  input wire logic dout_oe_o,
  input wire logic result_ready_strobe_o,
  input wire logic internal_clock_mode_i,
  input wire logic cfg_update_o
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge clock_i); endclocking
  default disable iff (!rst_n_i);
  // four samples cover the three-flop pin sync
  a_oe_released: assert property (cs_n_i [*4] |-> !dout_oe_o) else $error("dout driven, cs high");
  a_oe_driven: assert property (!cs_n_i [*4] |-> dout_oe_o) else $error("dout idle, cs low");
  a_strobe_ext_low: assert property (!internal_clock_mode_i [*2] |-> !result_ready_strobe_o)
    else $error("strobe high in external mode");
  a_strobe_rise_cause: assert property ($rose(result_ready_strobe_o) |-> $past(internal_clock_mode_i))
    else $error("strobe rose in external mode");
  a_dout_idle_hold: assert property (cs_n_i [*6] |=> $stable(dout_o)) else $error("dout shifted, cs high");
  a_no_update_idle: assert property (cs_n_i [*6] |-> !cfg_update_o) else $error("update, cs high");
  a_update_one_cycle: assert property (cfg_update_o |=> !cfg_update_o) else $error("long update");
  // a byte only completes on a rise seen with cs low, three samples back through the sync chain
  a_update_cause: assert property (cfg_update_o |-> !$past(cs_n_i, 3) && $past(sclk_i, 3) && !$past(sclk_i, 4))
    else $error("update without a clock rise");
  c_update: cover property (cfg_update_o);
  c_strobe: cover property ($rose(result_ready_strobe_o));
  c_frame: cover property ($rose(dout_oe_o));
endmodule : asp_port_props
bind asp_serial_port asp_port_props u_props (.clock_i(clock_i), .rst_n_i(rst_n_i), .cs_n_i(cs_n_i),
  .sclk_i(sclk_i), .dout_o(dout_o), .dout_oe_o(dout_oe_o), .result_ready_strobe_o(result_ready_strobe_o),
  .internal_clock_mode_i(internal_clock_mode_i), .cfg_update_o(cfg_update_o));
`default_nettype wire

// *** sim/asp_host_model.sv ***
// host master model driving the serial link pins
`default_nettype none
module asp_host_model
  import asp_pkg::*;
(
  input wire logic clock_i,
  input wire logic dout_i,
  output var asp_pins_type pins_o
);
  timeunit 1ns;
  timeprecision 1ps;
  localparam int HALF = 20; // 160 ns link period
  initial pins_o = '{cs_n: 1'h1, sclk: 1'h0, din: 1'h0};
  // one frame: config byte after leading zeros, result read on the second to fifteenth of the sixteen rises
  task automatic frame(input logic [7:0] cfg, output logic [13:0] rd);
    logic [15:0] word;
    word = {3'h0, cfg, 5'h0};
    rd = '0;
    @(negedge clock_i) pins_o.cs_n = 1'h0;
    repeat (8) @(negedge clock_i);
    for (int i = 15; i >= 0; i--) begin
      pins_o.din = word[i];
      repeat (HALF) @(negedge clock_i);
      pins_o.sclk = 1'h1;
      if (i < 15 && i > 0) rd = {rd[12:0], dout_i};
      repeat (HALF) @(negedge clock_i);
      pins_o.sclk = 1'h0;
    end
    repeat (HALF) @(negedge clock_i);
    pins_o.cs_n = 1'h1;
    pins_o.din = ~pins_o.din; // released line must not keep the last bit
  endtask : frame
  // clock and data toggling while deselected
  task automatic noise();
    for (int i = 0; i < 16; i++) begin
      repeat (HALF) @(negedge clock_i);
      pins_o.sclk = ~pins_o.sclk;
      pins_o.din = i[1];
    end
  endtask : noise
endmodule : asp_host_model
`default_nettype wire

// *** sim/asp_serial_port_bench.sv ***
// testbench for the converter serial port
`default_nettype none
module asp_serial_port_bench;
  timeunit 1ns;
  timeprecision 1ps;
  import asp_pkg::*;
  logic clock_i = 1'h0;
  logic rst_n_i = 1'h0;
  logic mode = 1'h1;
  logic push = 1'h0;
  logic [13:0] value = '0;
  logic [2:0] chan = '0;
  logic dout, dout_oe, strobe, ready, upd;
  logic [3:0] cfg;
  logic [13:0] seen;
  logic [13:0] exp_q [$];
  wire logic dout_pin;
  asp_pins_type pins;
  int fail_count = 0;
  int cmp_count = 0;
  int cycles = 0;
  int n = 0;
  int upd_n = 0;
  always #2 clock_i = ~clock_i;
  // update pulses counted off the launching edge, one per completed config byte
  always @(negedge clock_i) begin
    if (upd === 1'h1) upd_n++;
  end
  assign dout_pin = dout_oe ? dout : 1'bz; // strobe keeps its own line
  asp_host_model u_host (.clock_i(clock_i), .dout_i(dout_pin), .pins_o(pins));
  asp_serial_port u_dut (.clock_i(clock_i), .rst_n_i(rst_n_i), .cs_n_i(pins.cs_n), .sclk_i(pins.sclk),
    .din_i(pins.din), .dout_o(dout), .dout_oe_o(dout_oe), .result_ready_strobe_o(strobe),
    .internal_clock_mode_i(mode), .result_valid_i(push), .result_data_i(value), .result_ready_o(ready),
    .conv_channel_i(chan), .conv_cfg_o(cfg), .cfg_update_o(upd));
  task automatic check(input logic [13:0] got, input logic [13:0] want);
    cmp_count++;
    if (got !== want) begin
      fail_count++;
      $display("unexpected at %0t: got %h want %h", $time, got, want);
    end
  endtask : check
  task automatic stop_test();
    $display("compares %0d mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : stop_test
  task automatic put(input logic [13:0] v);
    @(negedge clock_i);
    push = 1'h1;
    value = v;
    @(negedge clock_i) push = 1'h0;
  endtask : put
  task automatic cfg_of(input int ch, input logic [3:0] want);
    @(negedge clock_i) chan = ch[2:0];
    repeat (2) @(negedge clock_i);
    check(14'(cfg), 14'(want));
  endtask : cfg_of
  // hang guard, well above the 13k cycles the tests need
  always @(posedge clock_i) begin
    cycles++;
    if (cycles == 20000) begin
      fail_count++;
      stop_test();
    end
  end
  initial begin
    repeat (6) @(negedge clock_i);
    rst_n_i = 1'h1;
    repeat (6) @(negedge clock_i);
    check(14'({dout_oe, strobe, cfg}), 14'h0);
    put(14'h2A5C);
    repeat (4) @(negedge clock_i);
    check(14'(strobe), 14'h1);
    mode = 1'h0;
    repeat (3) @(negedge clock_i);
    check(14'(strobe), 14'h0);
    u_host.frame(8'hAC, seen);
    check(seen, 14'h2A5C);
    repeat (4) @(negedge clock_i); // enable follows cs through the sync chain
    check(14'(dout_oe), 14'h0);
    cfg_of(2, 4'hC);
    cfg_of(3, 4'hC);
    cfg_of(1, 4'h0);
    u_host.noise();
    cfg_of(2, 4'hC);
    // fill until refused, then drain one word per frame
    mode = 1'h1;
    // ready lags the queue by a cycle, so look at it one edge after each push
    @(negedge clock_i);
    while (ready === 1'h1 && n < 40) begin
      exp_q.push_back(14'h1357 + 14'(n * 273));
      put(exp_q[n]);
      n++;
      @(negedge clock_i);
    end
    check(14'(n), 14'h11); // sixteen plus the output stage
    put(14'h3FFF);
    for (int k = 0; k < 18; k++) begin
      u_host.frame({1'h1, k[2:0], 1'h0, k[2:0]}, seen);
      check(seen, k < 17 ? exp_q[k] : 14'h0);
      cfg_of(k % 8, {1'h0, k[2:0]});
    end
    check(14'(strobe), 14'h0);
    check(14'(upd_n), 14'h13);
    stop_test();
  end
endmodule : asp_serial_port_bench
`default_nettype wire
